// ==== rtl/ief_top.v ====
// interrupt enable and request flag registers with request gating toward the core
//
// Functional notes
// [R1] enable bit 7 gates direct transfer requests; resets to 0, read/write
// [R2] enable bit 6 gates converter completion requests; resets to 0
// [R3] software writes only 0 to reserved enable bit 5; read value undefined
// [R4] enable bit 4 gates capture timer capture and overflow requests
// [R5] enable bits 3 and 2 gate timer F high and low half requests
// [R6] enable bit 1 gates up/down timer overflow and underflow requests
// [R7] enable bit 0 gates event counter requests; resets to 0
// [R8] accepting an interrupt never clears its request flag
// [R9] writing 0 clears a set flag; writing 1 has no effect
// [R10] pin flag bit 7 sets on timer A overflow; resets to 0
// [R11] software writes only 0 to reserved pin flag bit 6
// [R12] pin flag bit 5 always reads 1 and ignores writes
// [R13] pin flag bits 4 and 3 set on selected edge of enabled pins
// [R14] pin flag bits 1 and 0 set on selected edge of enabled pins
// [R15] pin flag bit 2 sets on selected edge of the event pin
// [R16] peripheral flag bit 7 sets on sleep direct transfer with transfer on
// [R17] peripheral flag bit 6 sets when conversion ends and start/busy clears
// [R18] pin flag register holds timer A, event pin and four pin flags
// [R19] each pin request reaches the core only when its enable is 1
// [R20] peripheral flag bit 1 sets on up/down timer overflow or underflow
// [R21] peripheral flag bit 0 sets on high byte, or either byte in 8-bit mode
// [R22] a set event in the same cycle as a clearing write wins
// [R23] each request line is its flag ANDed with its enable
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`include "ief_regs.vh"
module ief_top (
	input  wire       CLK,                // system clock, 40 MHz
	input  wire       SRST,               // synchronous reset, active high
	input  wire       CE,                 // clock enable, freezes all state when low
	input  wire [7:0] ADDR,               // register byte offset
	input  wire [7:0] WDATA,              // register write data
	input  wire       WR,                 // write strobe, one cycle
	input  wire       RD,                 // read strobe, one cycle
	output wire [7:0] RDATA,              // read data, cycle after the strobe
	input  wire [4:0] EXT_IRQ_PIN,        // external pins, bit 2 is the event pin
	input  wire       TIMER_A_OVF,        // timer A counter overflow pulse
	input  wire       TIMER_G_EVT,        // capture timer capture or overflow pulse
	input  wire       TIMER_FH_EVT,       // timer F high half match or overflow pulse
	input  wire       TIMER_FL_EVT,       // timer F low half match or overflow pulse
	input  wire       UPDOWN_TIMER_EVT,   // up/down timer overflow or underflow pulse
	input  wire       EVENT_COUNT_HIGH_OVF, // event counter high byte overflow pulse
	input  wire       EVENT_COUNT_LOW_OVF,  // event counter low byte overflow pulse
	input  wire       EVENT_COUNT_16BIT,  // event counter in 16-bit mode
	input  wire       SLEEP_TRANSFER,     // pulse: sleep made a direct power-mode transfer
	input  wire       DIRECT_TRANSFER_ON, // direct transfer control bit level
	input  wire       ADC_START_BUSY,     // converter start/busy flag level
	output wire [7:0] PIN_IRQ_REQ,        // gated requests, pin flag bit layout
	output wire [7:0] PERIPH_IRQ_REQ      // gated requests, peripheral flag bit layout
);

	////////////////////////////////////////////////////////////////////////////
	// read view of a register: implemented bits plus bits fixed at one
	function [7:0] reg_view;
		input [7:0] value;
		input [7:0] mask;
		input [7:0] ones;
		begin
			reg_view = (value & mask) | ones;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration and enable registers
	reg  [7:0] pin_func_reg;
	reg  [7:0] edge_sel_reg;
	reg  [7:0] pin_en_reg;
	reg  [7:0] periph_en_reg;
	reg  [7:0] rdata_reg;
	reg  [7:0] rdata_next;
	reg        adc_busy_reg;

	// address decode of write strobes
	reg        wr_pin_func;
	reg        wr_edge_sel;
	reg        wr_pin_en;
	reg        wr_periph_en;
	reg        wr_pin_flags;
	reg        wr_periph_flags;

	// flag bank wiring
	wire [7:0] pin_flags;
	wire [7:0] periph_flags;
	wire [7:0] pin_set;
	wire [7:0] periph_set;
	wire [4:0] pin_edge;
	wire       adc_done;
	wire       event_cnt_ovf;
	wire       direct_done;

	////////////////////////////////////////////////////////////////////////////
	// write decode
	always @*
	begin
		wr_pin_func     = 1'b0;
		wr_edge_sel     = 1'b0;
		wr_pin_en       = 1'b0;
		wr_periph_en    = 1'b0;
		wr_pin_flags    = 1'b0;
		wr_periph_flags = 1'b0;
		if (WR)
		begin
			if (ADDR == `IEF_ADDR_PIN_FUNC)
				wr_pin_func = 1'b1;
			else if (ADDR == `IEF_ADDR_EDGE_SEL)
				wr_edge_sel = 1'b1;
			else if (ADDR == `IEF_ADDR_PIN_EN)
				wr_pin_en = 1'b1;
			else if (ADDR == `IEF_ADDR_PERIPH_EN)
				wr_periph_en = 1'b1;
			else if (ADDR == `IEF_ADDR_PIN_FLAGS)
				wr_pin_flags = 1'b1;
			else if (ADDR == `IEF_ADDR_PERIPH_FLAGS)
				wr_periph_flags = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin function select and edge select registers
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			pin_func_reg <= `IEF_RST_REG;
			edge_sel_reg <= `IEF_RST_REG;
		end
		else if (CE)
		begin
			if (wr_pin_func)
				pin_func_reg <= WDATA & `IEF_MASK_PIN_FUNC;
			if (wr_edge_sel)
				edge_sel_reg <= WDATA & `IEF_MASK_EDGE_SEL;
		end
	end

	// pin enable register
	always @(posedge CLK)
	begin
		if (SRST)
			pin_en_reg <= `IEF_RST_REG;
		else if (CE && wr_pin_en)
			pin_en_reg <= WDATA & `IEF_MASK_PIN_EN;
	end

	// peripheral enable register; the reserved bit is not stored
	always @(posedge CLK)
	begin
		if (SRST)
			periph_en_reg <= `IEF_RST_REG; // R1 R2 R4 R5 R6 R7
		else if (CE && wr_periph_en)
			periph_en_reg <= WDATA & `IEF_MASK_PERIPH_EN; // R3
	end

	////////////////////////////////////////////////////////////////////////////
	// external pin synchronisation and edge detection
	ief_pin_edge #(
		.W        (5)
	) u_pin_edge (
		.CLK      (CLK),
		.SRST     (SRST),
		.CE       (CE),
		.PIN      (EXT_IRQ_PIN),
		.RISE_SEL (edge_sel_reg[4:0]),
		.EDGE     (pin_edge)
	);

	// previous start/busy level, to see its fall at conversion end
	always @(posedge CLK)
	begin
		if (SRST)
			adc_busy_reg <= 1'b0;
		else if (CE)
			adc_busy_reg <= ADC_START_BUSY;
	end

	////////////////////////////////////////////////////////////////////////////
	// set events of the pin flag register
	assign pin_set[`IEF_BIT_TIMER_A]   = TIMER_A_OVF; // R10 R18
	assign pin_set[6:5]                = 2'b00; // R11
	assign pin_set[`IEF_BIT_PIN4]      = pin_edge[4] & pin_func_reg[4]; // R13
	assign pin_set[`IEF_BIT_PIN3]      = pin_edge[3] & pin_func_reg[3]; // R13
	assign pin_set[`IEF_BIT_EVENT_PIN] = pin_edge[2] & pin_func_reg[2]; // R15
	assign pin_set[`IEF_BIT_PIN1]      = pin_edge[1] & pin_func_reg[1]; // R14
	assign pin_set[`IEF_BIT_PIN0]      = pin_edge[0] & pin_func_reg[0]; // R14

	// set events of the peripheral flag register
	assign direct_done   = SLEEP_TRANSFER & DIRECT_TRANSFER_ON; // R16
	assign adc_done      = adc_busy_reg & ~ADC_START_BUSY; // R17
	assign event_cnt_ovf = EVENT_COUNT_HIGH_OVF | (~EVENT_COUNT_16BIT & EVENT_COUNT_LOW_OVF); // R21

	assign periph_set[`IEF_BIT_DIRECT]    = direct_done;
	assign periph_set[`IEF_BIT_ADC]       = adc_done;
	assign periph_set[5]                  = 1'b0;
	assign periph_set[`IEF_BIT_TIMER_G]   = TIMER_G_EVT;
	assign periph_set[`IEF_BIT_TIMER_FH]  = TIMER_FH_EVT;
	assign periph_set[`IEF_BIT_TIMER_FL]  = TIMER_FL_EVT;
	assign periph_set[`IEF_BIT_TIMER_C]   = UPDOWN_TIMER_EVT; // R20
	assign periph_set[`IEF_BIT_EVENT_CNT] = event_cnt_ovf;

	////////////////////////////////////////////////////////////////////////////
	// sticky flag registers
	ief_flag_bank #(
		.W     (8),
		.MASK  (`IEF_MASK_PIN_FLAGS)
	) u_pin_flags (
		.CLK   (CLK),
		.SRST  (SRST),
		.CE    (CE),
		.SET   (pin_set),
		.WR    (wr_pin_flags),
		.WDATA (WDATA),
		.FLAGS (pin_flags)
	);

	ief_flag_bank #(
		.W     (8),
		.MASK  (`IEF_MASK_PERIPH_FLAGS)
	) u_periph_flags (
		.CLK   (CLK),
		.SRST  (SRST),
		.CE    (CE),
		.SET   (periph_set),
		.WR    (wr_periph_flags),
		.WDATA (WDATA),
		.FLAGS (periph_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// pin request lines: each flag ANDed with its own enable
	assign PIN_IRQ_REQ[`IEF_BIT_TIMER_A]   = pin_flags[`IEF_BIT_TIMER_A]
		& pin_en_reg[`IEF_BIT_TIMER_A]; // R23
	assign PIN_IRQ_REQ[6:5]                = 2'b00;
	assign PIN_IRQ_REQ[`IEF_BIT_PIN4]      = pin_flags[`IEF_BIT_PIN4]
		& pin_en_reg[`IEF_BIT_PIN4]; // R19 R23
	assign PIN_IRQ_REQ[`IEF_BIT_PIN3]      = pin_flags[`IEF_BIT_PIN3]
		& pin_en_reg[`IEF_BIT_PIN3]; // R19 R23
	assign PIN_IRQ_REQ[`IEF_BIT_EVENT_PIN] = pin_flags[`IEF_BIT_EVENT_PIN]
		& pin_en_reg[`IEF_BIT_EVENT_PIN]; // R23
	assign PIN_IRQ_REQ[`IEF_BIT_PIN1]      = pin_flags[`IEF_BIT_PIN1]
		& pin_en_reg[`IEF_BIT_PIN1]; // R19 R23
	assign PIN_IRQ_REQ[`IEF_BIT_PIN0]      = pin_flags[`IEF_BIT_PIN0]
		& pin_en_reg[`IEF_BIT_PIN0]; // R19 R23

	// peripheral request lines: each flag ANDed with its own enable
	assign PERIPH_IRQ_REQ[`IEF_BIT_DIRECT]    = periph_flags[`IEF_BIT_DIRECT]
		& periph_en_reg[`IEF_BIT_DIRECT]; // R1 R23
	assign PERIPH_IRQ_REQ[`IEF_BIT_ADC]       = periph_flags[`IEF_BIT_ADC]
		& periph_en_reg[`IEF_BIT_ADC]; // R2 R23
	assign PERIPH_IRQ_REQ[5]                  = 1'b0;
	assign PERIPH_IRQ_REQ[`IEF_BIT_TIMER_G]   = periph_flags[`IEF_BIT_TIMER_G]
		& periph_en_reg[`IEF_BIT_TIMER_G]; // R4 R23
	assign PERIPH_IRQ_REQ[`IEF_BIT_TIMER_FH]  = periph_flags[`IEF_BIT_TIMER_FH]
		& periph_en_reg[`IEF_BIT_TIMER_FH]; // R5 R23
	assign PERIPH_IRQ_REQ[`IEF_BIT_TIMER_FL]  = periph_flags[`IEF_BIT_TIMER_FL]
		& periph_en_reg[`IEF_BIT_TIMER_FL]; // R5 R23
	assign PERIPH_IRQ_REQ[`IEF_BIT_TIMER_C]   = periph_flags[`IEF_BIT_TIMER_C]
		& periph_en_reg[`IEF_BIT_TIMER_C]; // R6 R23
	assign PERIPH_IRQ_REQ[`IEF_BIT_EVENT_CNT] = periph_flags[`IEF_BIT_EVENT_CNT]
		& periph_en_reg[`IEF_BIT_EVENT_CNT]; // R7 R23

	////////////////////////////////////////////////////////////////////////////
	// read views: stored bits plus the bits that always read as one
	wire [7:0] pin_func_view;
	wire [7:0] edge_sel_view;
	wire [7:0] pin_en_view;
	wire [7:0] periph_en_view;
	wire [7:0] pin_flags_view;
	wire [7:0] periph_flags_view;

	assign pin_func_view     = reg_view(pin_func_reg, `IEF_MASK_PIN_FUNC, `IEF_ONES_NONE);
	assign edge_sel_view     = reg_view(edge_sel_reg, `IEF_MASK_EDGE_SEL, `IEF_ONES_EDGE_SEL);
	assign pin_en_view       = reg_view(pin_en_reg, `IEF_MASK_PIN_EN, `IEF_ONES_NONE);
	assign periph_en_view    = reg_view(periph_en_reg, `IEF_MASK_PERIPH_EN, `IEF_ONES_NONE);
	assign pin_flags_view    = reg_view(pin_flags, `IEF_MASK_PIN_FLAGS, `IEF_ONES_PIN_FLAGS);
	assign periph_flags_view = reg_view(periph_flags, `IEF_MASK_PERIPH_FLAGS, `IEF_ONES_NONE);

	// read multiplexer; unmapped offsets read as zero
	always @*
	begin
		rdata_next = 8'h00;
		if (ADDR == `IEF_ADDR_PIN_FUNC)
			rdata_next = pin_func_view;
		else if (ADDR == `IEF_ADDR_EDGE_SEL)
			rdata_next = edge_sel_view;
		else if (ADDR == `IEF_ADDR_PIN_EN)
			rdata_next = pin_en_view;
		else if (ADDR == `IEF_ADDR_PERIPH_EN)
			rdata_next = periph_en_view;
		else if (ADDR == `IEF_ADDR_PIN_FLAGS)
			rdata_next = pin_flags_view; // R12
		else if (ADDR == `IEF_ADDR_PERIPH_FLAGS)
			rdata_next = periph_flags_view;
	end

	// read data register: valid only in the cycle after the strobe
	always @(posedge CLK)
	begin
		if (SRST)
			rdata_reg <= 8'h00;
		else if (CE)
			rdata_reg <= RD ? rdata_next : 8'h00;
	end

	assign RDATA = rdata_reg;

endmodule

// ==== rtl/ief_regs.vh ====
// register offsets, bit positions, masks and reset values of the interrupt flag block
`ifndef IEF_REGS_VH
`define IEF_REGS_VH

// register byte offsets on the plain register port
`define IEF_ADDR_PIN_FUNC    8'hF0
`define IEF_ADDR_EDGE_SEL    8'hF2
`define IEF_ADDR_PIN_EN      8'hF3
`define IEF_ADDR_PERIPH_EN   8'hF4
`define IEF_ADDR_PIN_FLAGS   8'hF6
`define IEF_ADDR_PERIPH_FLAGS 8'hF7

// bit positions shared by enables and flags
`define IEF_BIT_TIMER_A      7
`define IEF_BIT_PIN4         4
`define IEF_BIT_PIN3         3
`define IEF_BIT_EVENT_PIN    2
`define IEF_BIT_PIN1         1
`define IEF_BIT_PIN0         0
`define IEF_BIT_DIRECT       7
`define IEF_BIT_ADC          6
`define IEF_BIT_TIMER_G      4
`define IEF_BIT_TIMER_FH     3
`define IEF_BIT_TIMER_FL     2
`define IEF_BIT_TIMER_C      1
`define IEF_BIT_EVENT_CNT    0

// implemented bits and bits that always read as one
`define IEF_MASK_PIN_FUNC    8'h1F
`define IEF_MASK_EDGE_SEL    8'h1F
`define IEF_ONES_EDGE_SEL    8'hE0
`define IEF_MASK_PIN_EN      8'h9F
`define IEF_MASK_PERIPH_EN   8'hDF
`define IEF_MASK_PIN_FLAGS   8'h9F
`define IEF_ONES_PIN_FLAGS   8'h20
`define IEF_MASK_PERIPH_FLAGS 8'hDF
`define IEF_ONES_NONE        8'h00

// reset values
`define IEF_RST_REG          8'h00
`define IEF_RST_PINS         5'h1F

`endif

// ==== rtl/ief_pin_edge.v ====
// pin synchroniser and selectable edge detector for external interrupt pins
`timescale 1ns/10ps
module ief_pin_edge #(
	parameter W = 5
) (
	input  wire         CLK,      // system clock
	input  wire         SRST,     // synchronous reset, active high
	input  wire         CE,       // clock enable, freezes state when low
	input  wire [W-1:0] PIN,      // raw pin levels from outside
	input  wire [W-1:0] RISE_SEL, // 1 selects rising edge, 0 falling
	output wire [W-1:0] EDGE      // one-cycle pulse on the selected edge
);

	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	reg [W-1:0] stable_reg;
	wire [W-1:0] agree;
	wire [W-1:0] change;

	// three-stage synchroniser; a change counts once stages two and three agree
	always @(posedge CLK)
	begin
		if (SRST)
		begin
			s1_reg     <= {W{1'b1}};
			s2_reg     <= {W{1'b1}};
			s3_reg     <= {W{1'b1}};
			stable_reg <= {W{1'b1}};
		end
		else if (CE)
		begin
			s1_reg <= PIN;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= (agree & s3_reg) | (~agree & stable_reg);
		end
	end

	// edge qualified by the agreed level and the selected direction
	assign agree  = ~(s2_reg ^ s3_reg);
	assign change = agree & (s3_reg ^ stable_reg);
	assign EDGE   = CE ? (change & ~(s3_reg ^ RISE_SEL)) : {W{1'b0}};

endmodule

// ==== rtl/ief_flag_bank.v ====
// bank of sticky request flags, set by events and cleared by writing zero
`timescale 1ns/10ps
module ief_flag_bank #(
	parameter       W    = 8,
	parameter [7:0] MASK = 8'hFF
) (
	input  wire         CLK,   // system clock
	input  wire         SRST,  // synchronous reset, active high
	input  wire         CE,    // clock enable
	input  wire [W-1:0] SET,   // one-cycle set events per flag
	input  wire         WR,    // write strobe for this bank
	input  wire [W-1:0] WDATA, // write data, zero bits clear
	output wire [W-1:0] FLAGS  // current flags
);

	reg  [W-1:0] flags_reg;
	wire [W-1:0] clr;
	wire [W-1:0] flags_next;

	// a written zero clears, a written one is ignored; set beats clear
	assign clr        = WR ? ~WDATA : {W{1'b0}}; // R9
	assign flags_next = ((flags_reg & ~clr) | SET) & MASK[W-1:0]; // R22

	// flags only change by events or writes, never by acceptance
	always @(posedge CLK)
	begin
		if (SRST)
			flags_reg <= {W{1'b0}};
		else if (CE)
			flags_reg <= flags_next; // R8
	end

	assign FLAGS = flags_reg;

endmodule

// ==== test/ief_src_model.sv ====
// event sources and pins standing around the interrupt flag block
`timescale 1ns/10ps
module ief_src_model (
	input  logic       clk,          // system clock
	output logic [7:0] evt = 8'h00,  // 7 sleep,6 timer a,5 low ovf,4 g,3 fh,2 fl,1 updown,0 high
	output logic [4:0] pin = 5'h1F,  // pin levels, idle high
	output logic       busy = 1'b0,  // converter start/busy level
	output logic       dt_on = 1'b0, // direct transfer control level
	output logic       mode16 = 1'b0 // event counter 16-bit mode
);
	// one-cycle event pulse with its qualifying levels held beside it
	task fire(input logic [7:0] m, input logic dt, input logic m16);
		@(posedge clk);
		evt <= m;
		dt_on <= dt;
		mode16 <= m16;
		@(posedge clk);
		evt <= 8'h00;
	endtask
	// conversion runs two cycles, then start/busy falls
	task adc_done;
		@(posedge clk);
		busy <= 1'b1;
		repeat (2) @(posedge clk);
		busy <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// new pin levels, then time for the synchroniser
	task set_pins(input logic [4:0] p);
		@(posedge clk);
		pin <= p;
		repeat (5) @(posedge clk);
	endtask
endmodule

// ==== test/ief_top_asserts.sv ====
// concurrent checks on the ports of the interrupt flag block
`timescale 1ns/10ps
`include "ief_regs.vh"
module ief_top_asserts (
	input wire logic       CLK,                  // clock
	input wire logic       SRST,                 // reset
	input wire logic       CE,                   // clock enable
	input wire logic [7:0] ADDR,                 // offset
	input wire logic [7:0] WDATA,                // write data
	input wire logic       WR,                   // write strobe
	input wire logic       RD,                   // read strobe
	input wire logic [7:0] RDATA,                // read data
	input wire logic       TIMER_A_OVF,          // timer a event
	input wire logic       UPDOWN_TIMER_EVT,     // up/down event
	input wire logic       EVENT_COUNT_HIGH_OVF, // high byte ovf
	input wire logic       EVENT_COUNT_LOW_OVF,  // low byte ovf
	input wire logic       EVENT_COUNT_16BIT,    // 16-bit mode
	input wire logic       SLEEP_TRANSFER,       // sleep transfer
	input wire logic       DIRECT_TRANSFER_ON,   // transfer on
	input wire logic       ADC_START_BUSY,       // busy level
	input wire logic [7:0] PIN_IRQ_REQ,          // pin requests
	input wire logic [7:0] PERIPH_IRQ_REQ        // peripheral requests
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// software clearing write aimed at the up/down timer flag
	sequence s_clr_tc;
		CE && WR && ADDR == `IEF_ADDR_PERIPH_FLAGS && !WDATA[1];
	endsequence
	a_pin_fixed_bits: assert property (
		CE && RD && ADDR == `IEF_ADDR_PIN_FLAGS |=> RDATA[6:5] == 2'b01)
		else $error("pin flag reserved bits wrong");
	a_rdata_idle: assert property (
		CE && !RD |=> RDATA == 8'h00)
		else $error("read data outside read cycle");
	a_freeze_reqs: assert property (
		!CE |=> $stable(PIN_IRQ_REQ) && $stable(PERIPH_IRQ_REQ))
		else $error("requests moved with clock enable low");
	a_req_reserved_low: assert property (
		PIN_IRQ_REQ[6:5] == 2'b00 && !PERIPH_IRQ_REQ[5])
		else $error("reserved request bit high");
	a_flag_holds: assert property (
		PIN_IRQ_REQ[7] && !WR |=> PIN_IRQ_REQ[7])
		else $error("timer a request dropped");
	a_set_wins: assert property (
		s_clr_tc ##0 (UPDOWN_TIMER_EVT && PERIPH_IRQ_REQ[1]) |=> PERIPH_IRQ_REQ[1])
		else $error("set lost against clear");
	a_clear_zero: assert property (
		s_clr_tc ##0 !UPDOWN_TIMER_EVT |=> !PERIPH_IRQ_REQ[1])
		else $error("zero write did not clear");
	a_direct_cause: assert property (
		$rose(PERIPH_IRQ_REQ[7]) |-> $past(WR)
		|| $past(SLEEP_TRANSFER) && $past(DIRECT_TRANSFER_ON))
		else $error("direct request without cause");
	a_updown_cause: assert property (
		$rose(PERIPH_IRQ_REQ[1]) |-> $past(WR) || $past(UPDOWN_TIMER_EVT))
		else $error("up/down request without cause");
	a_count_cause: assert property (
		$rose(PERIPH_IRQ_REQ[0]) |-> $past(WR) || $past(EVENT_COUNT_HIGH_OVF)
		|| $past(EVENT_COUNT_LOW_OVF) && !$past(EVENT_COUNT_16BIT))
		else $error("counter request without cause");
	a_adc_cause: assert property (
		$rose(PERIPH_IRQ_REQ[6]) |-> $past(WR)
		|| !$past(ADC_START_BUSY) && $past(ADC_START_BUSY, 2)
		|| !$past(ADC_START_BUSY, 2) && $past(ADC_START_BUSY, 3))
		else $error("converter request without fall");
	a_timer_a_cause: assert property (
		$rose(PIN_IRQ_REQ[7]) |-> $past(WR) || $past(TIMER_A_OVF))
		else $error("timer a request without cause");
endmodule
bind ief_top ief_top_asserts u_chk (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
	.CE(CE), .WR(WR), .RD(RD), .RDATA(RDATA), .TIMER_A_OVF(TIMER_A_OVF),
	.UPDOWN_TIMER_EVT(UPDOWN_TIMER_EVT), .EVENT_COUNT_HIGH_OVF(EVENT_COUNT_HIGH_OVF),
	.EVENT_COUNT_LOW_OVF(EVENT_COUNT_LOW_OVF), .EVENT_COUNT_16BIT(EVENT_COUNT_16BIT),
	.SLEEP_TRANSFER(SLEEP_TRANSFER), .DIRECT_TRANSFER_ON(DIRECT_TRANSFER_ON),
	.ADC_START_BUSY(ADC_START_BUSY), .PIN_IRQ_REQ(PIN_IRQ_REQ),
	.PERIPH_IRQ_REQ(PERIPH_IRQ_REQ));

// ==== test/tb_interrupt_enable_and_flag_regs.sv ====
// self-checking bench for the interrupt enable and flag block
`timescale 1ns/10ps
`include "ief_regs.vh"
module tb_interrupt_enable_and_flag_regs;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       ce = 1'b1;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	wire  [7:0] rdata, pin_req, per_req, evt;
	wire  [4:0] pin;
	wire        busy, dt_on, mode16;
	int         n_errors = 0;
	int         checks_done = 0;
	int         i;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	ief_src_model src (.clk(clk), .evt(evt), .pin(pin), .busy(busy), .dt_on(dt_on),
		.mode16(mode16));
	ief_top DUT (.CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .EXT_IRQ_PIN(pin), .TIMER_A_OVF(evt[6]),
		.TIMER_G_EVT(evt[4]), .TIMER_FH_EVT(evt[3]), .TIMER_FL_EVT(evt[2]),
		.UPDOWN_TIMER_EVT(evt[1]), .EVENT_COUNT_HIGH_OVF(evt[0]),
		.EVENT_COUNT_LOW_OVF(evt[5]), .EVENT_COUNT_16BIT(mode16),
		.SLEEP_TRANSFER(evt[7]), .DIRECT_TRANSFER_ON(dt_on), .ADC_START_BUSY(busy),
		.PIN_IRQ_REQ(pin_req), .PERIPH_IRQ_REQ(per_req));
	// compare and count
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle write, returns just after the edge that took it
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	// one-cycle read, data checked in the following cycle
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// verdict and end of run
	task finish_test;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (3000) @(posedge clk);
		n_errors++;
		finish_test;
	end
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd_reg(`IEF_ADDR_PERIPH_EN, 8'h00);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h20);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'h00);
		rd_reg(8'h10, 8'h00);
		wr_reg(`IEF_ADDR_PIN_FLAGS, 8'h9F);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h20);
		wr_reg(`IEF_ADDR_PERIPH_EN, 8'hDF);
		rd_reg(`IEF_ADDR_PERIPH_EN, 8'hDF);
		wr_reg(`IEF_ADDR_PERIPH_EN, 8'h00);
		// sources that must not set: low byte in 16-bit mode, sleep with transfer off
		src.fire(8'h20, 1'b1, 1'b1);
		src.fire(8'h80, 1'b0, 1'b0);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'h00);
		src.fire(8'h20, 1'b1, 1'b0);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'h01);
		src.fire(8'h9E, 1'b1, 1'b0);
		src.adc_done;
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'hDF);
		chk("periph_req", 8'h00, per_req);
		// each enable passes only its own source
		for (i = 0; i < 8; i++)
		begin
			if (i != 5)
			begin
				wr_reg(`IEF_ADDR_PERIPH_EN, 8'(8'h01 << i));
				chk("periph_req", 8'(8'h01 << i), per_req);
			end
		end
		// clear write meets a new event in the same cycle
		wr_reg(`IEF_ADDR_PERIPH_EN, 8'hDF);
		fork
			src.fire(8'h02, 1'b1, 1'b0);
			wr_reg(`IEF_ADDR_PERIPH_FLAGS, 8'hDD);
		join
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'hDF);
		wr_reg(`IEF_ADDR_PERIPH_FLAGS, 8'hDD);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'hDD);
		chk("periph_req", 8'hDD, per_req);
		// pins: event pin not configured, pin 4 waits for a rise
		wr_reg(`IEF_ADDR_PIN_EN, 8'h9F);
		wr_reg(`IEF_ADDR_PIN_FUNC, 8'h1B);
		wr_reg(`IEF_ADDR_EDGE_SEL, 8'h10);
		src.set_pins(5'h00);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h2B);
		chk("pin_req", 8'h0B, pin_req);
		src.fire(8'h40, 1'b1, 1'b0);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'hAB);
		wr_reg(`IEF_ADDR_PIN_FUNC, 8'h1F);
		wr_reg(`IEF_ADDR_EDGE_SEL, 8'h14);
		src.set_pins(5'h14);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'hBF);
		chk("pin_req", 8'h9F, pin_req);
		wr_reg(`IEF_ADDR_PIN_EN, 8'h80);
		chk("pin_req", 8'h80, pin_req);
		repeat (20) @(posedge clk);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'hBF);
		// clear timer A by a zero write; its event is lost while the clock enable is low
		wr_reg(`IEF_ADDR_PIN_FLAGS, 8'h1F);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h3F);
		@(posedge clk);
		ce <= 1'b0;
		src.fire(8'h40, 1'b0, 1'b0);
		@(posedge clk);
		ce <= 1'b1;
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h3F);
		// second reset in mid-run brings the peripheral enable and both flag registers back to their reset values
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rd_reg(`IEF_ADDR_PERIPH_EN, 8'h00);
		rd_reg(`IEF_ADDR_PIN_FLAGS, 8'h20);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'h00);
		chk("pin_req", 8'h00, pin_req);
		chk("periph_req", 8'h00, per_req);
		// high byte overflow sets the counter flag in 16-bit mode
		src.fire(8'h01, 1'b0, 1'b1);
		rd_reg(`IEF_ADDR_PERIPH_FLAGS, 8'h01);
		finish_test;
	end
endmodule
